// *** rfs_pkg.sv ***
`default_nettype none
// Shared constants of the regulator fault supervisor.
package rfs_pkg;

   // Boost hold after a transition ends, 50 us in 8 ns cycles.
   localparam int BOOST_HOLD_CYC = 6250;
   // Final reference to ready, 93 us in 8 ns cycles.
   localparam int READY_DELAY_CYC = 11625;

   // Number of power channels.
   localparam int NUM_CH = 3;
   // Overcurrent events without a good soft-start that latch the supervisor; the event before the limit still retries.
   localparam logic [2:0] OC_RETRY_LIMIT = 3'h5;

   // Register byte offsets.
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_EVENT = 12'h008;
   localparam logic [11:0] ADDR_LIMIT = 12'h00C;

   // Control register fields.
   localparam int CTRL_FORCE_OFF_BIT = 0;
   localparam logic CTRL_FORCE_OFF_RESET = 1'b0;

   // Status register fields.
   localparam int ST_STATE_LSB = 0;
   localparam int ST_READY_BIT = 3;
   localparam int ST_UV_BIT = 4;
   localparam int ST_OV_BIT = 5;
   localparam int ST_BOOST_BIT = 6;
   localparam int ST_OVSEEN_BIT = 7;
   localparam int ST_RETRY_LSB = 8;

   // Sticky event register fields, write one to clear.
   localparam int EV_OV_BIT = 0;
   localparam int EV_OC_BIT = 1;
   localparam int EV_UV_BIT = 2;
   localparam int EV_OCL_BIT = 3;
   localparam int EV_LATCH_BIT = 4;
   localparam int EV_WIDTH = 5;
   localparam logic [4:0] EVENT_RESET = 5'h00;

   // Supervisor states.
   typedef enum logic [2:0] {
      RFS_OFF = 3'b000,
      RFS_SOFT = 3'b001,
      RFS_DELAY = 3'b010,
      RFS_RUN = 3'b011,
      RFS_RETRY = 3'b100,
      RFS_LATCH = 3'b101
   } rfs_state_e;

endpackage
`default_nettype wire

// *** rfs_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; a change is accepted once stages two and three agree.
module rfs_sync #(
   parameter int WIDTH = 1
) (
   // Clock, reset and enable.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // Asynchronous inputs and their filtered copies.
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // Refuse an empty bus.
   generate
      if (WIDTH < 1) begin : g_chk
         $error("rfs_sync needs WIDTH of at least one");
      end
   endgenerate

   // All synchroniser state.
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;
   } rfs_sync_s;

   rfs_sync_s r;
   rfs_sync_s n;

   // Stage one is only read by stage two, so metastability stays contained.
   always_comb begin
      n = r;
      n.s1 = async_in;
      n.s2 = r.s1;
      n.s3 = r.s2;
      for (int i = 0; i < WIDTH; i++) begin
         // Disagreeing stages keep the old value.
         if (r.s2[i] == r.s3[i]) begin
            n.q[i] = r.s3[i];
         end
      end
   end

   // State register, frozen while the enable is low.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else if (clk_en) begin
         r <= n;
      end
   end

   assign sync_out = r.q;

endmodule
`default_nettype wire

// *** rfs_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
// Delay timer: expired rises CYCLES edges after run rises.
module rfs_timer #(
   parameter int CYCLES = 16
) (
   // Clock, reset and enable.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // Control and result.
   input wire logic run,
   output logic expired
);

   localparam int CW = $clog2(CYCLES + 1);

   // Refuse a zero-length delay.
   generate
      if (CYCLES < 1) begin : g_chk
         $error("rfs_timer needs CYCLES of at least one");
      end
   endgenerate

   // All timer state.
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic done;
   } rfs_timer_s;

   rfs_timer_s r;
   rfs_timer_s n;

   // Count while running; dropping run restarts the delay from zero.
   always_comb begin
      n = r;
      if (!run) begin
         n.cnt = '0;
         n.done = 1'b0;
      end else if (!r.done) begin
         if (r.cnt == CW'(CYCLES - 1)) begin
            n.done = 1'b1;
         end else begin
            n.cnt = r.cnt + CW'(1);
         end
      end
   end

   // State register, frozen while the enable is low.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else if (clk_en) begin
         r <= n;
      end
   end

   assign expired = r.done;

endmodule
`default_nettype wire

// *** rfs_supervisor.sv ***
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module rfs_supervisor #(
   parameter int NUM_CH = rfs_pkg::NUM_CH,
   parameter int BOOST_HOLD_CYC = rfs_pkg::BOOST_HOLD_CYC,
   parameter int READY_DELAY_CYC = rfs_pkg::READY_DELAY_CYC
) (
   // Clock, reset and clock enable.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Enable pin from the host.
   input wire logic enable_pin,
   // Same-clock inputs from the reference and modulator logic.
   input wire logic no_cpu_code,
   input wire logic reference_final,
   input wire logic dyn_code_active,
   input wire logic [NUM_CH-1:0] pwm_high,
   input wire logic [NUM_CH-1:0] pwm_low,
   // Analog comparator pins on the sensed output voltage.
   input wire logic uv_below_half,
   input wire logic uv_above_restore,
   input wire logic ov_above_fixed,
   input wire logic ov_above_ref,
   input wire logic ov_release_fixed,
   input wire logic ov_release_ref,
   // Analog comparator pins on current.
   input wire logic avg_over_normal,
   input wire logic avg_over_boost,
   input wire logic current_monitor_over,
   input wire logic [NUM_CH-1:0] ch_over_normal,
   input wire logic [NUM_CH-1:0] ch_over_boost,
   // Open-drain ready pin.
   output logic regulator_ready_out,
   output logic regulator_ready_out_oe_n,
   // Gate drives and soft-start ramp request.
   output logic [NUM_CH-1:0] upper_gate_drive,
   output logic [NUM_CH-1:0] lower_gate_drive,
   output logic soft_start_run
);

   // Refuse channel counts that the limit register cannot show.
   generate
      if (NUM_CH < 1 || NUM_CH > 8) begin : g_chk
         $error("rfs_supervisor needs NUM_CH between one and eight");
      end
   endgenerate

   // Width of the bundle of pin inputs that pass the synchroniser.
   localparam int SW = 10 + 2 * NUM_CH;

   // All supervisor state.
   typedef struct packed {
      rfs_pkg::rfs_state_e state;
      logic [2:0] retry_cnt;
      logic ov_active;
      logic ov_soft;
      logic ov_seen;
      logic uv_low;
      logic dyn_prev;
      logic hold_armed;
      logic ready;
      logic ss_run;
      logic [NUM_CH-1:0] upper;
      logic [NUM_CH-1:0] lower;
      logic [NUM_CH-1:0] limiting;
      logic force_off;
      logic [rfs_pkg::EV_WIDTH-1:0] events;
      logic [31:0] rdata;
      logic err;
   } rfs_core_s;

   rfs_core_s r;
   rfs_core_s n;

   // Synchronised pin copies.
   logic [SW-1:0] pins_s;
   logic en_s;
   logic uvh_s;
   logic uvr_s;
   logic ovf_s;
   logic ovr_s;
   logic rlf_s;
   logic rlr_s;
   logic avn_s;
   logic avb_s;
   logic mon_s;
   logic [NUM_CH-1:0] chn_s;
   logic [NUM_CH-1:0] chb_s;

   // Timer results.
   logic hold_done;
   logic ready_done;

   // Matches a word address against a register offset.
   function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] offs);
      return addr[11:2] == offs[11:2];
   endfunction

   // Every comparator and the enable come from outside this clock domain.
   rfs_sync #(
      .WIDTH(SW)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .async_in({ch_over_boost, ch_over_normal, current_monitor_over, avg_over_boost, avg_over_normal,
                 ov_release_ref, ov_release_fixed, ov_above_ref, ov_above_fixed,
                 uv_above_restore, uv_below_half, enable_pin}),
      .sync_out(pins_s)
   );

   assign {chb_s, chn_s, mon_s, avb_s, avn_s, rlr_s, rlf_s, ovr_s, ovf_s, uvr_s, uvh_s, en_s} = pins_s;

   // Hold timer that keeps the limits boosted after a transition ends.
   rfs_timer #(
      .CYCLES(BOOST_HOLD_CYC)
   ) u_hold (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .run(r.hold_armed & ~dyn_code_active),
      .expired(hold_done)
   );

   // Delay from the final reference to ready; it runs only in the delay state.
   rfs_timer #(
      .CYCLES(READY_DELAY_CYC)
   ) u_ready (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .run(r.state == rfs_pkg::RFS_DELAY),
      .expired(ready_done)
   );

   // Combinational helpers for the next-state process.
   logic enable_ok;
   logic boost;
   logic in_soft;
   logic ov_trip;
   logic ov_release;
   logic oc_event;
   logic [NUM_CH-1:0] ch_over;
   logic setup;
   logic wr_access;
   logic [rfs_pkg::EV_WIDTH-1:0] ev_set;
   logic [rfs_pkg::EV_WIDTH-1:0] ev_clr;
   logic [31:0] rd_mux;

   // Fault qualification.
   always_comb begin
      // Software can hold the regulator off just like the enable pin.
      enable_ok = en_s & ~r.force_off;
      // Boost lasts from a transition's start, through the arming cycle, until the hold expires.
      boost = dyn_code_active | r.dyn_prev | (r.hold_armed & ~hold_done);
      in_soft = (r.state == rfs_pkg::RFS_SOFT);
      // While ramping the higher level trips, so both must be exceeded.
      ov_trip = in_soft ? (ovf_s & ovr_s) : ovr_s;
      // Release below either level minus the margin after a soft-start trip, otherwise below the reference level only.
      ov_release = r.ov_soft ? (rlf_s | rlr_s) : rlr_s;
      // Two independent overcurrent comparators feed one event.
      oc_event = (boost ? avb_s : avn_s) | mon_s;
      ch_over = boost ? chb_s : chn_s;
   end

   // Bus decode; read data are captured in the setup cycle.
   always_comb begin
      setup = psel & ~penable;
      wr_access = psel & penable & pwrite;
      rd_mux = 32'h0000_0000;
      if (reg_hit(paddr, rfs_pkg::ADDR_CTRL)) begin
         rd_mux[rfs_pkg::CTRL_FORCE_OFF_BIT] = r.force_off;
      end else if (reg_hit(paddr, rfs_pkg::ADDR_STATUS)) begin
         rd_mux[rfs_pkg::ST_STATE_LSB +: 3] = r.state;
         rd_mux[rfs_pkg::ST_READY_BIT] = r.ready;
         rd_mux[rfs_pkg::ST_UV_BIT] = r.uv_low;
         rd_mux[rfs_pkg::ST_OV_BIT] = r.ov_active;
         rd_mux[rfs_pkg::ST_BOOST_BIT] = boost;
         rd_mux[rfs_pkg::ST_OVSEEN_BIT] = r.ov_seen;
         rd_mux[rfs_pkg::ST_RETRY_LSB +: 3] = r.retry_cnt;
      end else if (reg_hit(paddr, rfs_pkg::ADDR_EVENT)) begin
         rd_mux[rfs_pkg::EV_WIDTH-1:0] = r.events;
      end else if (reg_hit(paddr, rfs_pkg::ADDR_LIMIT)) begin
         rd_mux[NUM_CH-1:0] = r.limiting;
      end
      ev_clr = '0;
      if (wr_access && reg_hit(paddr, rfs_pkg::ADDR_EVENT)) begin
         ev_clr = pwdata[rfs_pkg::EV_WIDTH-1:0];
      end
   end

   // Next state of the whole supervisor.
   always_comb begin
      n = r;
      ev_set = '0;

      // Register writes and the captured read answer.
      if (setup) begin
         n.rdata = rd_mux;
         // Anything outside the four words is answered with an error.
         n.err = (paddr[11:4] != 8'h00);
      end
      if (wr_access && reg_hit(paddr, rfs_pkg::ADDR_CTRL)) begin
         n.force_off = pwdata[rfs_pkg::CTRL_FORCE_OFF_BIT];
      end

      // Boost hold is armed when a transition ends and cleared on expiry or a new one.
      n.dyn_prev = dyn_code_active;
      if (r.dyn_prev && !dyn_code_active) begin
         n.hold_armed = 1'b1;
      end else if (dyn_code_active || hold_done) begin
         n.hold_armed = 1'b0;
      end

      // Undervoltage has hysteresis; a new dip wins over the restore level.
      if (uvh_s) begin
         n.uv_low = 1'b1;
         ev_set[rfs_pkg::EV_UV_BIT] = ~r.uv_low;
      end else if (uvr_s) begin
         n.uv_low = 1'b0;
      end

      // Overvoltage is watched in every state, so an open sense line is always caught.
      if (!r.ov_active && ov_trip) begin
         n.ov_active = 1'b1;
         n.ov_soft = in_soft;
         ev_set[rfs_pkg::EV_OV_BIT] = 1'b1;
      end else if (r.ov_active && ov_release) begin
         n.ov_active = 1'b0;
         if (r.ov_soft && !r.ov_seen && in_soft) begin
            // The first soft-start event only uses up the allowance.
            n.ov_seen = 1'b1;
         end else begin
            n.state = rfs_pkg::RFS_LATCH;
            ev_set[rfs_pkg::EV_LATCH_BIT] = (r.state != rfs_pkg::RFS_LATCH);
         end
      end else if (!r.ov_active) begin
         // The sequencer pauses while overvoltage protection holds the output.
         unique case (r.state)
            rfs_pkg::RFS_OFF: begin
               // Reset and enable low both land here.
               n.retry_cnt = 3'h0;
               n.ov_seen = 1'b0;
               if (enable_ok && !no_cpu_code) begin
                  n.state = rfs_pkg::RFS_SOFT;
               end
            end
            rfs_pkg::RFS_SOFT, rfs_pkg::RFS_DELAY, rfs_pkg::RFS_RUN: begin
               if (!enable_ok) begin
                  n.state = rfs_pkg::RFS_OFF;
               end else if (no_cpu_code) begin
                  n.state = rfs_pkg::RFS_LATCH;
                  ev_set[rfs_pkg::EV_LATCH_BIT] = 1'b1;
               end else if (oc_event) begin
                  ev_set[rfs_pkg::EV_OC_BIT] = 1'b1;
                  n.retry_cnt = r.retry_cnt + 3'h1;
                  if (r.retry_cnt == rfs_pkg::OC_RETRY_LIMIT - 3'h1) begin
                     n.state = rfs_pkg::RFS_LATCH;
                     ev_set[rfs_pkg::EV_LATCH_BIT] = 1'b1;
                  end else begin
                     n.state = rfs_pkg::RFS_RETRY;
                  end
               end else if (r.state == rfs_pkg::RFS_SOFT && reference_final) begin
                  n.state = rfs_pkg::RFS_DELAY;
               end else if (r.state == rfs_pkg::RFS_DELAY && ready_done) begin
                  // Success only once the ready delay has run out.
                  n.state = rfs_pkg::RFS_RUN;
                  n.retry_cnt = 3'h0;
               end
            end
            rfs_pkg::RFS_RETRY: begin
               // One cycle with every gate off, then the ramp starts over.
               n.state = enable_ok ? rfs_pkg::RFS_SOFT : rfs_pkg::RFS_OFF;
            end
            rfs_pkg::RFS_LATCH: begin
               // Only dropping the enable pin or setting force_off leaves the latched state.
               if (!enable_ok) begin
                  n.state = rfs_pkg::RFS_OFF;
               end
            end
            default: begin
               n.state = rfs_pkg::RFS_OFF;
            end
         endcase
      end

      // Gate drives follow the state being entered.
      n.limiting = '0;
      if (n.ov_active) begin
         // Every lower switch on pulls the output down hard.
         n.upper = '0;
         n.lower = '1;
      end else if (n.state == rfs_pkg::RFS_SOFT || n.state == rfs_pkg::RFS_DELAY ||
                   n.state == rfs_pkg::RFS_RUN) begin
         for (int i = 0; i < NUM_CH; i++) begin
            // A channel over its limit is cut short without stopping the others.
            n.upper[i] = pwm_high[i] & ~ch_over[i];
            n.lower[i] = pwm_low[i] | ch_over[i];
            n.limiting[i] = ch_over[i];
         end
         ev_set[rfs_pkg::EV_OCL_BIT] = |ch_over;
      end else begin
         // Shutdown, retry and latch keep every switch off.
         n.upper = '0;
         n.lower = '0;
      end

      // Ready is high only in the run state with no fault pending.
      n.ready = (n.state == rfs_pkg::RFS_RUN) & ~n.ov_active & ~n.uv_low & ~oc_event;
      n.ss_run = (n.state == rfs_pkg::RFS_SOFT) & ~n.ov_active;

      // A new event in the same cycle as its clear is kept.
      n.events = (r.events & ~ev_clr) | ev_set;
   end

   // State register, frozen while the clock enable is low.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.state <= rfs_pkg::RFS_OFF;
         r.force_off <= rfs_pkg::CTRL_FORCE_OFF_RESET;
         r.events <= rfs_pkg::EVENT_RESET;
      end else if (clk_en) begin
         r <= n;
      end
   end

   // Zero-wait slave; the error flag is shown only in the access phase.
   assign pready = 1'b1;
   assign pslverr = r.err & psel & penable;
   assign prdata = r.rdata;

   // The ready pin only ever pulls low; enable low means driving.
   assign regulator_ready_out = 1'b0;
   assign regulator_ready_out_oe_n = r.ready;
   assign upper_gate_drive = r.upper;
   assign lower_gate_drive = r.lower;
   assign soft_start_run = r.ss_run;

endmodule
`default_nettype wire

// *** rfs_supervisor_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the fault supervisor.
module rfs_supervisor_monitor #(
   parameter int NUM_CH = 3,
   parameter int READY_DELAY_CYC = 5
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Bus error.
   input wire logic pslverr,
   // Modulator and comparator inputs.
   input wire logic [NUM_CH-1:0] pwm_high,
   input wire logic [NUM_CH-1:0] ch_over_normal,
   input wire logic [NUM_CH-1:0] ch_over_boost,
   input wire logic uv_below_half,
   input wire logic ov_above_fixed,
   input wire logic ov_above_ref,
   input wire logic ov_release_fixed,
   input wire logic ov_release_ref,
   input wire logic avg_over_normal,
   input wire logic avg_over_boost,
   input wire logic current_monitor_over,
   // Outputs under watch.
   input wire logic regulator_ready_out_oe_n,
   input wire logic [NUM_CH-1:0] upper_gate_drive,
   input wire logic [NUM_CH-1:0] lower_gate_drive,
   input wire logic soft_start_run
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Cycles since soft-start ended; zero until one is seen.
   logic [15:0] since_ss_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) since_ss_r <= 16'h0000;
      else if (soft_start_run) since_ss_r <= 16'h0001;
      else if (since_ss_r != 16'h0000 && since_ss_r != 16'hFFFF) since_ss_r <= since_ss_r + 16'h0001;
   end
   property p_no_ready_soft;
      soft_start_run |-> !regulator_ready_out_oe_n;
   endproperty
   a_no_ready_soft: assert property (p_no_ready_soft) else $error("ready released in soft-start");
   property p_ready_delay;
      $rose(regulator_ready_out_oe_n) |-> since_ss_r >= READY_DELAY_CYC - 1;
   endproperty
   a_ready_delay: assert property (p_ready_delay) else $error("ready rose too early");
   property p_upper_req;
      (upper_gate_drive & ~$past(pwm_high)) == '0;
   endproperty
   a_upper_req: assert property (p_upper_req) else $error("upper gate without request");
   property p_ch_limit;
      (ch_over_normal[1] && ch_over_boost[1]) [*7] |-> !upper_gate_drive[1];
   endproperty
   a_ch_limit: assert property (p_ch_limit) else $error("channel limit ignored");
   property p_ov_gates;
      (ov_above_fixed && ov_above_ref && !ov_release_fixed && !ov_release_ref) [*7]
         |-> &lower_gate_drive && upper_gate_drive == '0 && !regulator_ready_out_oe_n;
   endproperty
   a_ov_gates: assert property (p_ov_gates) else $error("overvoltage drive wrong");
   property p_uv_ready;
      uv_below_half [*7] |-> !regulator_ready_out_oe_n;
   endproperty
   a_uv_ready: assert property (p_uv_ready) else $error("ready high in undervoltage");
   property p_mon_oc;
      current_monitor_over [*7] |-> !regulator_ready_out_oe_n;
   endproperty
   a_mon_oc: assert property (p_mon_oc) else $error("ready high on monitor overcurrent");
   property p_avg_oc;
      (avg_over_normal && avg_over_boost) [*7] |-> !regulator_ready_out_oe_n;
   endproperty
   a_avg_oc: assert property (p_avg_oc) else $error("ready high on average overcurrent");
   c_ready: cover property ($rose(regulator_ready_out_oe_n));
   c_ov: cover property (&lower_gate_drive);
   c_err: cover property (pslverr);
endmodule
`default_nettype wire

// *** rfs_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Host and system monitor on the ready wire.
module rfs_host_model (
   // Ready pin as the supervisor drives it.
   input wire logic regulator_ready_out,
   input wire logic regulator_ready_out_oe_n,
   // Host request and the enable pin.
   input wire logic host_enable,
   output logic enable_pin,
   // Level the monitor sees.
   output logic ready_seen
);
   // The pull-up lifts the released wire.
   assign ready_seen = regulator_ready_out_oe_n ? 1'b1 : regulator_ready_out;
   // Enable is a plain level from the host.
   assign enable_pin = host_enable;
endmodule
`default_nettype wire

// *** rfs_supervisor_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module rfs_supervisor_bench;
   // Clock, reset and bus signals.
   logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic pready, pslverr, e, host_enable = 1'b0, enable_pin, ready_seen, no_cpu_code = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   // Stimulus.
   logic reference_final = 1'b0, dyn_code_active = 1'b0, uv_below_half = 1'b0, uv_above_restore = 1'b0;
   logic ov_above = 1'b0, ov_release = 1'b0, avg_over = 1'b0, current_monitor_over = 1'b0;
   logic [2:0] pwm_high = 3'h0, pwm_low = 3'h0, ch_over_normal = 3'h0, ch_over_boost = 3'h0;
   logic regulator_ready_out, regulator_ready_out_oe_n, soft_start_run;
   logic [2:0] upper_gate_drive, lower_gate_drive;
   int err_total = 0, num_checks = 0;
   always #4 pclk = ~pclk;
   // Short hold and delay keep the run brief.
   rfs_supervisor #(.NUM_CH(3), .BOOST_HOLD_CYC(4), .READY_DELAY_CYC(5)) DUT (
      .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .enable_pin, .no_cpu_code, .reference_final, .dyn_code_active, .pwm_high, .pwm_low,
      .uv_below_half, .uv_above_restore, .ov_above_fixed(ov_above), .ov_above_ref(ov_above),
      .ov_release_fixed(ov_release), .ov_release_ref(ov_release), .avg_over_normal(avg_over),
      .avg_over_boost(avg_over), .current_monitor_over, .ch_over_normal, .ch_over_boost,
      .regulator_ready_out, .regulator_ready_out_oe_n, .upper_gate_drive, .lower_gate_drive, .soft_start_run);
   rfs_host_model HOST (.regulator_ready_out, .regulator_ready_out_oe_n, .host_enable, .enable_pin, .ready_seen);
   // Verdict and end of run.
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic timeout();
      err_total++;
      $display("MISMATCH %0t wait ran out", $time);
      results();
   endtask
   task automatic chk_reg(input logic [31:0] g, input logic [31:0] x);
      num_checks++;
      if (g !== x) begin
         err_total++;
         $display("MISMATCH %0t reg %h exp %h", $time, g, x);
      end
   endtask
   task automatic chk_pin(input logic [2:0] g, input logic [2:0] x);
      num_checks++;
      if (g !== x) begin
         err_total++;
         $display("MISMATCH %0t pin %b exp %b", $time, g, x);
      end
   endtask
   // Look 1 ns after the edge, once outputs settle.
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   // One APB transfer, held until pready is seen high.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
         if (n > 20) timeout();
      end while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task automatic st(input logic [31:0] m, input logic [31:0] x);
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk_reg(rd & m, x);
   endtask
   task automatic wait_rdy(input logic v);
      int n;
      n = 0;
      while (ready_seen !== v) begin
         cyc(1);
         n++;
         if (n > 200) timeout();
      end
      num_checks++;
   endtask
   // Overvoltage held, then released.
   task automatic ov_trip();
      @(posedge pclk) ov_above <= 1'b1;
      cyc(7);
      chk_pin(lower_gate_drive, 3'h7);
      chk_pin(upper_gate_drive | {2'b00, ready_seen}, 3'h0);
      @(posedge pclk) begin
         ov_above <= 1'b0;
         ov_release <= 1'b1;
      end
      cyc(7);
      @(posedge pclk) ov_release <= 1'b0;
      cyc(2);
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      cyc(1);
      chk_pin(upper_gate_drive | lower_gate_drive, 3'h0);
      chk_pin({2'b00, ready_seen}, 3'h0);
      st(32'h0000_000F, 32'h0000_0000);
      @(posedge pclk) host_enable <= 1'b1;
      cyc(8);
      st(32'h0000_000F, 32'h0000_0001);
      chk_pin({2'b00, soft_start_run}, 3'h1);
      @(posedge pclk) reference_final <= 1'b1;
      wait_rdy(1'b1);
      st(32'h0000_000F, 32'h0000_000B);
      $display("test start done");
      @(posedge pclk) pwm_high <= 3'h7;
      cyc(3);
      chk_pin(upper_gate_drive, 3'h7);
      @(posedge pclk) ch_over_normal <= 3'h2;
      cyc(7);
      chk_pin(upper_gate_drive, 3'h5);
      chk_pin(lower_gate_drive | {2'b00, ready_seen}, 3'h3);
      @(posedge pclk) dyn_code_active <= 1'b1;
      cyc(3);
      chk_pin(upper_gate_drive, 3'h7);
      @(posedge pclk) ch_over_boost <= 3'h2;
      cyc(7);
      chk_pin(upper_gate_drive, 3'h5);
      @(posedge pclk) ch_over_boost <= 3'h0;
      cyc(7);
      chk_pin(upper_gate_drive, 3'h7);
      @(posedge pclk) dyn_code_active <= 1'b0;
      cyc(2);
      chk_pin(upper_gate_drive, 3'h7);
      cyc(8);
      chk_pin(upper_gate_drive, 3'h5);
      @(posedge pclk) ch_over_normal <= 3'h0;
      $display("test channel limit done");
      @(posedge pclk) uv_below_half <= 1'b1;
      cyc(7);
      chk_pin({ready_seen, upper_gate_drive[1:0]}, 3'h3);
      @(posedge pclk) begin
         uv_below_half <= 1'b0;
         uv_above_restore <= 1'b1;
      end
      wait_rdy(1'b1);
      @(posedge pclk) uv_above_restore <= 1'b0;
      @(posedge pclk) avg_over <= 1'b1;
      cyc(7);
      chk_pin({2'b00, ready_seen}, 3'h0);
      @(posedge pclk) avg_over <= 1'b0;
      wait_rdy(1'b1);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk_reg(rd & 32'h0000_0002, 32'h0000_0002);
      $display("test undervoltage and retry done");
      @(posedge pclk) current_monitor_over <= 1'b1;
      cyc(60);
      st(32'h0000_000F, 32'h0000_0005);
      chk_pin(upper_gate_drive | lower_gate_drive, 3'h0);
      @(posedge pclk) current_monitor_over <= 1'b0;
      cyc(10);
      st(32'h0000_000F, 32'h0000_0005);
      @(posedge pclk) host_enable <= 1'b0;
      cyc(8);
      st(32'h0000_070F, 32'h0000_0000);
      @(posedge pclk) host_enable <= 1'b1;
      wait_rdy(1'b1);
      $display("test overcurrent latch done");
      ov_trip();
      st(32'h0000_0007, 32'h0000_0005);
      ov_trip();
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk_pin({2'b00, e}, 3'h1);
      @(posedge pclk) begin
         host_enable <= 1'b0;
         reference_final <= 1'b0;
      end
      cyc(8);
      @(posedge pclk) host_enable <= 1'b1;
      cyc(8);
      ov_trip();
      st(32'h0000_0007, 32'h0000_0001);
      ov_trip();
      st(32'h0000_0007, 32'h0000_0005);
      $display("test overvoltage done");
      @(posedge pclk) host_enable <= 1'b0;
      cyc(8);
      @(posedge pclk) begin
         host_enable <= 1'b1;
         reference_final <= 1'b1;
      end
      wait_rdy(1'b1);
      @(posedge pclk) no_cpu_code <= 1'b1;
      cyc(4);
      chk_pin({2'b00, ready_seen}, 3'h0);
      st(32'h0000_0007, 32'h0000_0005);
      apb(1'b1, 12'h000, 32'h0000_0001);
      st(32'h0000_0007, 32'h0000_0000);
      $display("test no-cpu code done");
      results();
   end
endmodule
bind rfs_supervisor rfs_supervisor_monitor #(.NUM_CH(NUM_CH), .READY_DELAY_CYC(READY_DELAY_CYC)) MON (
   .pclk, .presetn, .pslverr, .pwm_high, .ch_over_normal, .ch_over_boost, .uv_below_half,
   .ov_above_fixed, .ov_above_ref, .ov_release_fixed, .ov_release_ref, .avg_over_normal, .avg_over_boost,
   .current_monitor_over, .regulator_ready_out_oe_n, .upper_gate_drive, .lower_gate_drive, .soft_start_run);
`default_nettype wire
